// *** pkg/timer16_irq_pkg.sv ***
// constants and types of the timer interrupt flag block
package timer16_irq_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_MASK  = 12'h000;
  localparam logic [11:0] ADDR_FLAGS = 12'h004;
  localparam logic [11:0] ADDR_CTRL  = 12'h008;

  localparam int BIT_CAPTURE = 5;
  localparam int BIT_CMP_B   = 2;
  localparam int BIT_CMP_A   = 1;
  localparam int BIT_WRAP    = 0;
  localparam int BIT_EDGE    = 0;

  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET  = 4'h0;
  localparam logic       EDGE_RESET  = 1'b0;

  // ----------------------------------------------------------------
  // waveform modes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_NORMAL     = 4'h0;
  localparam logic [3:0] MODE_CLR_CMP_A  = 4'h4;
  localparam logic [3:0] MODE_CLR_CAPT   = 4'hc;
  localparam logic [3:0] MODE_PC_CAPT    = 4'h8;
  localparam logic [3:0] MODE_PFC_CAPT   = 4'ha;
  localparam logic [3:0] MODE_FAST_CAPT  = 4'he;

  // one bit per interrupt source, compact order
  typedef struct packed {
    logic capture;
    logic cmp_b;
    logic cmp_a;
    logic wrap;
  } irq_src_type;

endpackage

// *** verilog/timer16_irq_flags.sv ***
// interrupt flags, masks and requests of the 16-bit timer
`timescale 1ns/10ps
module timer16_irq_flags (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [15:0]                  counter_value,
  input  wire logic [15:0]                  cmp_a_value,
  input  wire logic [15:0]                  cmp_b_value,
  input  wire logic [15:0]                  capture_value,
  input  wire logic [3:0]                   waveform_mode_sel,
  input  wire logic                         wrap_max_event,
  input  wire logic                         wrap_mode_event,
  input  wire logic                         capture_pin,
  input  wire logic                         global_irq_enable,
  input  wire timer16_irq_pkg::irq_src_type vector_ack,
  output timer16_irq_pkg::irq_src_type      irq_request,
  output logic                              irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  timer16_irq_pkg::irq_src_type flags_q;
  timer16_irq_pkg::irq_src_type flags_d;
  timer16_irq_pkg::irq_src_type mask_q;
  timer16_irq_pkg::irq_src_type set_vec;
  timer16_irq_pkg::irq_src_type clr_vec;
  timer16_irq_pkg::irq_src_type req_q;
  logic                         irq_q;
  logic                         edge_rising_q;
  logic                         pin_meta_q;
  logic                         pin_sync_q;
  logic                         pin_prev_q;
  logic                         cmp_a_hit_q;
  logic                         cmp_b_hit_q;
  logic                         top_hit_q;
  logic                         pready_q;
  logic                         pslverr_q;
  logic [31:0]                  prdata_q;
  logic [31:0]                  rdata_d;
  logic                         addr_ok;
  logic                         wr_take;
  logic                         wr_low_lane;
  logic                         capt_is_top;
  logic                         wrap_on_max;
  logic                         pin_edge;

  // ----------------------------------------------------------------
  // register layout helpers
  // ----------------------------------------------------------------
  // compact source vector to the printed bit layout
  function automatic logic [31:0] spread(
    input timer16_irq_pkg::irq_src_type v
  );
    logic [31:0] r;
    r = 32'h0000_0000;
    r[timer16_irq_pkg::BIT_CAPTURE] = v.capture;
    r[timer16_irq_pkg::BIT_CMP_B]   = v.cmp_b;
    r[timer16_irq_pkg::BIT_CMP_A]   = v.cmp_a;
    r[timer16_irq_pkg::BIT_WRAP]    = v.wrap;
    return r;
  endfunction

  // unused positions are never picked up
  function automatic timer16_irq_pkg::irq_src_type gather(
    input logic [31:0] w
  );
    timer16_irq_pkg::irq_src_type r;
    r.capture = w[timer16_irq_pkg::BIT_CAPTURE];
    r.cmp_b   = w[timer16_irq_pkg::BIT_CMP_B];
    r.cmp_a   = w[timer16_irq_pkg::BIT_CMP_A];
    r.wrap    = w[timer16_irq_pkg::BIT_WRAP];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  always_comb begin
    addr_ok = (paddr == timer16_irq_pkg::ADDR_MASK) ||
              (paddr == timer16_irq_pkg::ADDR_FLAGS) ||
              (paddr == timer16_irq_pkg::ADDR_CTRL);
  end

  // write lands at the access edge only, and only on a mapped word
  always_comb begin
    wr_take     = psel && penable && pready_q && pwrite && addr_ok;
    wr_low_lane = wr_take && pstrb[0];
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (paddr)
      timer16_irq_pkg::ADDR_MASK:  rdata_d = spread(mask_q);
      timer16_irq_pkg::ADDR_FLAGS: rdata_d = spread(flags_q);
      timer16_irq_pkg::ADDR_CTRL:
        rdata_d[timer16_irq_pkg::BIT_EDGE] = edge_rising_q;
      default:                     rdata_d = 32'h0000_0000;
    endcase
  end

  // no wait state, yet every bus output comes from a flop loaded in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= psel && !penable;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr_q <= !addr_ok;
    end else if (!psel) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= timer16_irq_pkg::MASK_RESET;
    end else if (wr_low_lane &&
                 paddr == timer16_irq_pkg::ADDR_MASK) begin
      mask_q <= gather(pwdata);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_rising_q <= timer16_irq_pkg::EDGE_RESET;
    end else if (wr_low_lane &&
                 paddr == timer16_irq_pkg::ADDR_CTRL) begin
      edge_rising_q <= pwdata[timer16_irq_pkg::BIT_EDGE];
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  always_comb begin
    capt_is_top = (waveform_mode_sel == timer16_irq_pkg::MODE_CLR_CAPT) ||
                  (waveform_mode_sel == timer16_irq_pkg::MODE_PC_CAPT) ||
                  (waveform_mode_sel == timer16_irq_pkg::MODE_PFC_CAPT) ||
                  (waveform_mode_sel == timer16_irq_pkg::MODE_FAST_CAPT);
    wrap_on_max = (waveform_mode_sel == timer16_irq_pkg::MODE_NORMAL) ||
                  (waveform_mode_sel == timer16_irq_pkg::MODE_CLR_CMP_A) ||
                  (waveform_mode_sel == timer16_irq_pkg::MODE_CLR_CAPT);
  end

  // ----------------------------------------------------------------
  // capture pin
  // ----------------------------------------------------------------
  // pin is asynchronous; first stage only feeds the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      pin_meta_q <= capture_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  always_comb begin
    if (edge_rising_q) begin
      pin_edge = pin_sync_q && !pin_prev_q;
    end else begin
      pin_edge = !pin_sync_q && pin_prev_q;
    end
  end

  // ----------------------------------------------------------------
  // counter matches
  // ----------------------------------------------------------------
  // a match is held one cycle, so the flag follows the next cycle;
  // forced compare strobes are not wired in here at all
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_a_hit_q <= 1'b0;
      cmp_b_hit_q <= 1'b0;
      top_hit_q   <= 1'b0;
    end else begin
      cmp_a_hit_q <= counter_value == cmp_a_value;
      cmp_b_hit_q <= counter_value == cmp_b_value;
      top_hit_q   <= capt_is_top &&
                     counter_value == capture_value;
    end
  end

  // ----------------------------------------------------------------
  // flag set and clear
  // ----------------------------------------------------------------
  always_comb begin
    set_vec.cmp_a   = cmp_a_hit_q;
    set_vec.cmp_b   = cmp_b_hit_q;
    set_vec.capture = capt_is_top ? top_hit_q
                                  : pin_edge;
    set_vec.wrap    = wrap_on_max ? wrap_max_event
                                  : wrap_mode_event;
  end

  // ack is a one-cycle pulse from the core
  always_comb begin
    clr_vec = vector_ack;
    if (wr_low_lane && paddr == timer16_irq_pkg::ADDR_FLAGS) begin
      // a written zero leaves a flag alone
      clr_vec = clr_vec | gather(pwdata);
    end
  end

  always_comb begin
    flags_d = (flags_q & ~clr_vec) | set_vec;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= timer16_irq_pkg::FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------
  // built from the next flag value so a cleared flag drops at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= 4'h0;
    end else begin
      req_q.cmp_a   <= flags_d.cmp_a && mask_q.cmp_a &&
                       global_irq_enable;
      req_q.wrap    <= flags_d.wrap && mask_q.wrap &&
                       global_irq_enable;
      req_q.cmp_b   <= flags_d.cmp_b && mask_q.cmp_b &&
                       global_irq_enable;
      req_q.capture <= flags_d.capture && mask_q.capture &&
                       global_irq_enable;
    end
  end

  // summary line ignores the global enable; the core gates it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_d & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    prdata      = prdata_q;
    pready      = pready_q;
    pslverr     = pslverr_q;
    irq_request = req_q;
    irq         = irq_q;
  end

endmodule

// *** tb/irq_flags_checker.sv ***
// assertion checker of the timer interrupt flag block
`timescale 1ns/10ps
module irq_flags_checker (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic [3:0]                   pstrb,
  input wire logic [31:0]                  prdata,
  input wire logic                         pready,
  input wire logic [15:0]                  counter_value,
  input wire logic [15:0]                  cmp_a_value,
  input wire logic [15:0]                  cmp_b_value,
  input wire logic [3:0]                   waveform_mode_sel,
  input wire logic                         wrap_max_event,
  input wire logic                         wrap_mode_event,
  input wire logic                         global_irq_enable,
  input wire timer16_irq_pkg::irq_src_type vector_ack,
  input wire timer16_irq_pkg::irq_src_type irq_request
);
  logic [1:0] hit_q;
  logic [5:0] mask_q;
  logic       ge, wev;
  // ------------------------------------------------------------
  // shadow mask and compare hits
  // ------------------------------------------------------------
  assign ge = global_irq_enable;
  assign wev = (waveform_mode_sel inside {timer16_irq_pkg::MODE_NORMAL,
               timer16_irq_pkg::MODE_CLR_CMP_A,
               timer16_irq_pkg::MODE_CLR_CAPT}) ?
               wrap_max_event : wrap_mode_event;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_q  <= 2'h0;
      mask_q <= 6'h00;
    end else begin
      hit_q <= {counter_value == cmp_b_value, counter_value == cmp_a_value};
      if (psel && penable && pready && pwrite && pstrb[0] &&
          paddr == timer16_irq_pkg::ADDR_MASK) mask_q <= pwdata[5:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_gie_cmp_a: assert property (irq_request.cmp_a |-> $past(ge))
    else $error("compare-A request without global enable");
  a_gie_wrap: assert property (irq_request.wrap |-> $past(ge))
    else $error("overflow request without global enable");
  a_rsvd_zero: assert property (
    pready |-> prdata[7:6] == 2'h0 && prdata[4:3] == 2'h0)
    else $error("reserved bits read nonzero");
  a_set_cmp_a: assert property (
    hit_q[0] && mask_q[1] && ge |=> irq_request.cmp_a)
    else $error("compare-A flag missed the following cycle");
  a_set_cmp_b: assert property (
    hit_q[1] && mask_q[2] && ge |=> irq_request.cmp_b)
    else $error("compare-B flag missed the following cycle");
  a_set_wrap: assert property (
    wev && mask_q[0] && ge |=> irq_request.wrap)
    else $error("overflow flag missed");
  a_ack_cmp_a: assert property (
    vector_ack.cmp_a && !hit_q[0] |=> !irq_request.cmp_a)
    else $error("compare-A ack did not clear");
  a_ack_cmp_b: assert property (
    vector_ack.cmp_b && !hit_q[1] |=> !irq_request.cmp_b)
    else $error("compare-B ack did not clear");
endmodule
bind timer16_irq_flags irq_flags_checker i_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .counter_value, .cmp_a_value, .cmp_b_value, .waveform_mode_sel,
  .wrap_max_event, .wrap_mode_event, .global_irq_enable, .vector_ack,
  .irq_request);

// *** tb/irq_core_model.sv ***
// behavioural interrupt core that enters pending vectors
`timescale 1ns/10ps
module irq_core_model (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         en,
  input  wire timer16_irq_pkg::irq_src_type irq_request,
  output timer16_irq_pkg::irq_src_type      vector_ack
);
  // ------------------------------------------------------------
  // vector entry, one-cycle ack; slow answers by holding en low
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) vector_ack <= 4'h0;
    else if (en && irq_request != 4'h0 && vector_ack == 4'h0)
      vector_ack <= irq_request;
    else vector_ack <= 4'h0;
  end
endmodule

// *** tb/tb.sv ***
// self-checking bench of the timer interrupt flag block
`timescale 1ns/10ps
module tb;
  localparam logic [11:0] MK = timer16_irq_pkg::ADDR_MASK;
  localparam logic [11:0] FL = timer16_irq_pkg::ADDR_FLAGS;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, capture_pin = 1'b0, global_irq_enable = 1'b0;
  logic        wrap_max_event = 1'b0, wrap_mode_event = 1'b0, ack_en = 1'b0;
  logic        pready, pslverr, irq;
  logic [3:0]  pstrb = 4'hf, waveform_mode_sel = 4'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [15:0] counter_value = 16'h0, cmp_a_value, cmp_b_value, capture_value;
  logic [32:0] exp_q[$];
  int          n_fail = 0, tests_run = 0;
  timer16_irq_pkg::irq_src_type vector_ack, irq_request;
  timer16_irq_flags i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .counter_value, .cmp_a_value,
    .cmp_b_value, .capture_value, .waveform_mode_sel, .wrap_max_event,
    .wrap_mode_event, .capture_pin, .global_irq_enable, .vector_ack,
    .irq_request, .irq);
  irq_core_model i_core (.pclk, .presetn, .en(ack_en), .irq_request,
    .vector_ack);
  always #2.5 pclk = ~pclk;
  task automatic chk(string nm, logic [32:0] e, logic [32:0] s);
    tests_run++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      n_fail++;
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
    int n;
    n = 0;
    if (!w) exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 40);
    if (n >= 40) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] e, logic er = 1'b0);
    apb(1'b0, a, 32'h0, {er, e});
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic hit(logic [15:0] v);
    counter_value <= v;
    @(posedge pclk);
    counter_value <= 16'h0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic req_is(logic [3:0] e, logic i);
    chk("irq", {28'h0, i, e}, {28'h0, irq, irq_request});
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // read data is compared at the access edge, oldest note first
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk("rdata", exp_q.pop_front(), {pslverr, prdata});
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    test_done;
  end
  initial begin
    void'($urandom(47437));
    cmp_a_value = 16'h0001 + 16'($urandom % 1000);
    cmp_b_value = 16'h07d1 + 16'($urandom % 1000);
    capture_value = 16'h0fa1 + 16'($urandom % 1000);
    r = $urandom;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(FL, 32'h0);
    rd(12'h00c, 32'h0, 1'b1);
    rd(timer16_irq_pkg::ADDR_CTRL, 32'h0);
    wr(MK, r);
    rd(MK, r & 32'h27);
    wr(MK, 32'h27);
    // a write with the low byte lane off must leave the mask alone
    pstrb <= 4'h0;
    wr(MK, 32'h0);
    pstrb <= 4'hf;
    rd(MK, 32'h27);
    $display("test registers done");
    global_irq_enable <= 1'b1;
    hit(cmp_a_value);
    req_is(4'h2, 1'b1);
    wr(FL, 32'hfd);
    rd(FL, 32'h2);
    wr(FL, 32'h2);
    rd(FL, 32'h0);
    global_irq_enable <= 1'b0;
    hit(cmp_b_value);
    req_is(4'h0, 1'b1);
    wr(FL, 32'h4);
    wrap_max_event <= 1'b1;
    @(posedge pclk);
    wrap_max_event <= 1'b0;
    rd(FL, 32'h1);
    wr(FL, 32'h1);
    rd(FL, 32'h0);
    $display("test compare and wrap done");
    global_irq_enable <= 1'b1;
    waveform_mode_sel <= 4'h8;
    wrap_max_event <= 1'b1;
    @(posedge pclk);
    wrap_max_event <= 1'b0;
    wrap_mode_event <= 1'b1;
    @(posedge pclk);
    wrap_mode_event <= 1'b0;
    hit(cmp_a_value);
    hit(cmp_b_value);
    rd(FL, 32'h7);
    ack_en <= 1'b1;
    repeat (4) @(posedge pclk);
    req_is(4'h0, 1'b0);
    ack_en <= 1'b0;
    $display("test vector ack done");
    waveform_mode_sel <= 4'hc;
    hit(capture_value);
    req_is(4'h8, 1'b1);
    wr(FL, 32'h20);
    capture_pin <= 1'b1;
    repeat (2) @(posedge pclk);
    capture_pin <= 1'b0;
    repeat (6) @(posedge pclk);
    rd(FL, 32'h0);
    waveform_mode_sel <= 4'h0;
    wr(timer16_irq_pkg::ADDR_CTRL, 32'h1);
    rd(timer16_irq_pkg::ADDR_CTRL, 32'h1);
    capture_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    wr(FL, 32'h0);
    rd(FL, 32'h20);
    $display("test capture done");
    // match lands on the same edge as the write-one clear
    fork
      wr(FL, 32'h22);
      begin
        @(posedge pclk);
        counter_value <= cmp_a_value;
        @(posedge pclk);
        counter_value <= 16'h0;
      end
    join
    rd(FL, 32'h2);
    $display("test set wins done");
    // reset in mid-run: pin is high, falling-edge default must ignore it
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(MK, 32'h0);
    rd(FL, 32'h0);
    req_is(4'h0, 1'b0);
    $display("test mid-run reset done");
    test_done;
  end
endmodule
